// ===== rtsc_pkg.sv
// shared constants for the reference and temperature sense control block
package rtsc_pkg;

	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned DATA_W         = 8;

	// register offsets (word index on the plain register port)
	localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
	localparam logic [3:0]  STATUS_OFFSET  = 4'h1;

	// control register field positions
	localparam int unsigned REF_ON_BIT     = 7;
	localparam int unsigned READY_BIT      = 6;
	localparam int unsigned TEMP_ON_BIT    = 5;
	localparam int unsigned TEMP_RANGE_BIT = 4;
	localparam int unsigned CMP_GAIN_LSB   = 2;
	localparam int unsigned ADC_GAIN_LSB   = 0;
	localparam int unsigned GAIN_W         = 2;

	// status register field positions
	localparam int unsigned CMP_SETTLED_BIT = 0;
	localparam int unsigned ADC_SETTLED_BIT = 1;
	localparam int unsigned TEMP_CONV_BIT   = 2;

	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	// bits that software may change; ready flag is excluded
	localparam logic [7:0]  CTRL_WR_MASK   = 8'hBF;

	// gain field encodings
	localparam logic [1:0]  GAIN_OFF       = 2'h0;
	localparam logic [1:0]  GAIN_X1        = 2'h1;
	localparam logic [1:0]  GAIN_X2        = 2'h2;
	localparam logic [1:0]  GAIN_X4        = 2'h3;

	// timing, in nanoseconds
	localparam int unsigned REF_SETTLE_NS  = 20000;
	localparam int unsigned BUF_SETTLE_NS  = 30000;
	localparam int unsigned TEMP_ACQ_NS    = 200000;

	// least time in cycles, rounded up, never below one
	function automatic int unsigned rtsc_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : rtsc_cycles

	localparam int unsigned REF_SETTLE_CYC = rtsc_cycles(REF_SETTLE_NS);
	localparam int unsigned BUF_SETTLE_CYC = rtsc_cycles(BUF_SETTLE_NS);
	localparam int unsigned TEMP_ACQ_CYC   = rtsc_cycles(TEMP_ACQ_NS);

	// one-hot gain select: bit0 x1, bit1 x2, bit2 x4; all zero is off
	function automatic logic [2:0] rtsc_gain_decode(input logic [1:0] code);
		logic [2:0] sel;
		sel = 3'h0;
		unique case (code)
			GAIN_X4: sel = 3'h4;
			GAIN_X2: sel = 3'h2;
			GAIN_X1: sel = 3'h1;
			GAIN_OFF: sel = 3'h0;
		endcase
		return sel;
	endfunction : rtsc_gain_decode

endpackage : rtsc_pkg

// ===== rtsc_settle_if.sv
// carrier between the control register and the reference settle timer
`timescale 1ns/1ps
interface rtsc_settle_if;
	logic refOn;
	logic ready;

	modport ctrl   (output refOn, input ready);
	modport settle (input refOn, output ready);
endinterface : rtsc_settle_if

// ===== rtsc_settle.sv
// reference settle timer: ready flag after a fixed count from enable
`timescale 1ns/1ps
module rtsc_settle
	import rtsc_pkg::*;
#(
	parameter int unsigned CYCLES = REF_SETTLE_CYC
) (
	input  wire logic      ref_clk,
	input  wire logic      rst,
	rtsc_settle_if.settle  link
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);

	logic [CW-1:0] count;
	logic          readyQ;

	if (CYCLES < 1) begin : g_chk
		$error("rtsc_settle: CYCLES must be at least one");
	end

	// restart on enable
	// restart whenever the enable is low, so every rise starts afresh
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (!link.refOn) begin
			count <= '0;
		end else if (count != LAST) begin
			count <= count + CW'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readyQ <= 1'b0;
		end else begin
			readyQ <= link.refOn && (count >= LAST - CW'(1));
		end
	end

	// immediate clear
	// gated by the live enable so a clear takes effect at once
	assign link.ready = readyQ & link.refOn;
endmodule : rtsc_settle

// ===== rtsc_gain_buf.sv
// one gain buffer: decoded select and settle status
`timescale 1ns/1ps
module rtsc_gain_buf
	import rtsc_pkg::*;
#(
	parameter int unsigned CYCLES = BUF_SETTLE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [1:0] gainCode,
	output logic            bufOn,
	output logic [2:0]      gainSel,
	output logic            settled
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);

	logic [CW-1:0] count;
	logic          next_on;

	if (CYCLES < 1) begin : g_chk
		$error("rtsc_gain_buf: CYCLES must be at least one");
	end

	assign next_on = (gainCode != GAIN_OFF);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gainSel <= 3'h0;
			bufOn   <= 1'b0;
		end else begin
			gainSel <= rtsc_gain_decode(gainCode);
			bufOn   <= next_on;
		end
	end

	// only switching the buffer on restarts settling, not a gain change
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (!next_on) begin
			count <= '0;
		end else if (count != LAST) begin
			count <= count + CW'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			settled <= 1'b0;
		end else begin
			settled <= next_on && (count >= LAST - CW'(1));
		end
	end
endmodule : rtsc_gain_buf

// ===== rtsc_ctrl.sv
// reference and temperature sense control register block
//
// Operation
// - reference on follows control bit 7
// - bit 6 reads reference ready state
// - standard-supply variant reads ready always one
// - temperature sensor on follows bit 5
// - bit 4 high range, else low
// - bits 3-2 decode comparator/DAC gain
// - bits 1-0 decode converter gain
// - all writable fields clear on reset
// - sensor output routed to reserved channel
// - ready only after reference has settled
`timescale 1ns/1ps
module rtsc_ctrl
	import rtsc_pkg::*;
#(
	parameter int unsigned ADDR_W      = 4,
	parameter bit          STD_SUPPLY  = 1'b0,
	parameter int unsigned REF_CYC     = REF_SETTLE_CYC,
	parameter int unsigned BUF_CYC     = BUF_SETTLE_CYC,
	parameter int unsigned TEMP_CYC    = TEMP_ACQ_CYC
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [7:0]        regWrData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [7:0]             regRdData,
	output logic                   refEnable,
	output logic                   refReady,
	output logic                   tempSensorOn,
	output logic                   tempRangeHigh,
	output logic                   tempToConverter,
	output logic                   cmpDacBufOn,
	output logic [2:0]             cmpDacGain,
	output logic                   adcBufOn,
	output logic [2:0]             adcGain,
	input  wire logic              convMuxTemp,
	input  wire logic              convStart,
	output logic                   tempConvAllowed
);
	localparam int unsigned TW = $clog2(TEMP_CYC + 1);
	localparam logic [TW-1:0] TEMP_LOAD = TW'(TEMP_CYC);

	logic [7:0]    ctrl;
	logic [7:0]    next_ctrl;
	logic [7:0]    next_rdData;
	logic [7:0]    statusWord;
	logic [TW-1:0] tempWait;
	logic          cmpSettled;
	logic          adcSettled;
	logic          ctrlHit;
	logic          statusHit;

	rtsc_settle_if settleIf ();

	if (ADDR_W < 4) begin : g_chk_addr
		$error("rtsc_ctrl: ADDR_W must hold the register offsets");
	end
	if (TEMP_CYC < 1) begin : g_chk_temp
		$error("rtsc_ctrl: TEMP_CYC must be at least one");
	end

	assign ctrlHit   = (regAddr == ADDR_W'(CTRL_OFFSET));
	assign statusHit = (regAddr == ADDR_W'(STATUS_OFFSET));

	always_comb begin
		next_ctrl = ctrl;
		if (regWrite && ctrlHit) begin
			next_ctrl = (regWrData & CTRL_WR_MASK) | (ctrl & ~CTRL_WR_MASK);
		end
		next_ctrl[READY_BIT] = 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	assign settleIf.refOn = ctrl[REF_ON_BIT];
	assign refEnable      = ctrl[REF_ON_BIT];

	rtsc_settle #(
		.CYCLES (REF_CYC)
	) u_settle (
		.ref_clk (ref_clk),
		.rst     (rst),
		.link    (settleIf.settle)
	);

	assign refReady = STD_SUPPLY ? 1'b1 : settleIf.ready;

	assign tempSensorOn  = ctrl[TEMP_ON_BIT];
	assign tempRangeHigh = ctrl[TEMP_RANGE_BIT];
	assign tempToConverter = ctrl[TEMP_ON_BIT];

	rtsc_gain_buf #(
		.CYCLES (BUF_CYC)
	) u_cmp_buf (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.gainCode (ctrl[CMP_GAIN_LSB +: GAIN_W]),
		.bufOn    (cmpDacBufOn),
		.gainSel  (cmpDacGain),
		.settled  (cmpSettled)
	);

	rtsc_gain_buf #(
		.CYCLES (BUF_CYC)
	) u_adc_buf (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.gainCode (ctrl[ADC_GAIN_LSB +: GAIN_W]),
		.bufOn    (adcBufOn),
		.gainSel  (adcGain),
		.settled  (adcSettled)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tempWait <= TEMP_LOAD;
		end else if (!convMuxTemp || !ctrl[TEMP_ON_BIT] || convStart) begin
			tempWait <= TEMP_LOAD;
		end else if (tempWait != '0) begin
			tempWait <= tempWait - TW'(1);
		end
	end

	// advisory only: the converter is not blocked by this block
	assign tempConvAllowed = convMuxTemp && ctrl[TEMP_ON_BIT] &&
		(tempWait == '0);

	always_comb begin
		statusWord = 8'h00;
		statusWord[CMP_SETTLED_BIT] = cmpSettled;
		statusWord[ADC_SETTLED_BIT] = adcSettled;
		statusWord[TEMP_CONV_BIT]   = tempConvAllowed;
	end

	always_comb begin
		next_rdData = 8'h00;
		if (regRead && ctrlHit) begin
			next_rdData = ctrl;
			next_rdData[READY_BIT] = refReady;
		end else if (regRead && statusHit) begin
			next_rdData = statusWord;
		end
	end

	// unmapped reads and idle cycles return zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= next_rdData;
		end
	end

	// helper: cycles since reference enable rose
	localparam int unsigned AW = $clog2(REF_CYC + 2);
	logic [AW-1:0] refAge;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			refAge <= '0;
		end else if (!refEnable) begin
			refAge <= '0;
		end else if (refAge != AW'(REF_CYC + 1)) begin
			refAge <= refAge + AW'(1);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_ref_enable_write: assert property (
		regWrite && ctrlHit |=> refEnable == $past(regWrData[REF_ON_BIT]))
		else $error("reference enable does not follow write");

	chk_ready_when_off: assert property (
		!refEnable && !STD_SUPPLY |-> !refReady && regRdData[READY_BIT] == 1'b0
			|| $past(regRead) && $past(ctrlHit) && $past(refReady))
		else $error("ready flag set while reference off");

	chk_std_ready_one: assert property (
		STD_SUPPLY |-> refReady)
		else $error("ready flag low on standard-supply variant");

	chk_sensor_enable: assert property (
		regWrite && ctrlHit |=> tempSensorOn == $past(regWrData[TEMP_ON_BIT])
			&& tempToConverter == tempSensorOn)
		else $error("sensor enable or routing wrong");

	chk_range_select: assert property (
		regWrite && ctrlHit |=>
			tempRangeHigh == $past(regWrData[TEMP_RANGE_BIT]))
		else $error("range select does not follow write");

	chk_cmp_gain_decode: assert property (
		regWrite && ctrlHit && regWrData[3:2] == GAIN_X4 |=> ##1
			cmpDacGain == 3'h4 && cmpDacBufOn)
		else $error("comparator gain x4 not decoded");

	chk_adc_gain_decode: assert property (
		regWrite && ctrlHit && regWrData[1:0] == GAIN_OFF |=> ##1
			adcGain == 3'h0 && !adcBufOn)
		else $error("converter gain off not decoded");

	chk_reset_clear: assert property (
		$fell(rst) |-> ctrl == CTRL_RESET)
		else $error("control register not cleared by reset");

	chk_ready_after_settle: assert property (
		refReady && !STD_SUPPLY |-> refAge >= AW'(REF_CYC))
		else $error("ready flag before settle count");

	chk_ready_clear_now: assert property (
		$fell(refEnable) && !STD_SUPPLY |-> !refReady)
		else $error("ready flag not cleared with enable");

	chk_ready_write_ignored: assert property (
		regWrite && ctrlHit |=> ctrl[READY_BIT] == 1'b0)
		else $error("ready bit stored from write");

	chk_temp_wait: assert property (
		$rose(convMuxTemp) |-> !tempConvAllowed [*8])
		else $error("conversion allowed too soon after select");

	chk_temp_reload: assert property (
		convStart |=> !tempConvAllowed)
		else $error("conversion allowed right after a start");

	chk_cmp_gain_x2: assert property (
		regWrite && ctrlHit && regWrData[3:2] == GAIN_X2 |=> ##1
			cmpDacGain == 3'h2 && cmpDacBufOn)
		else $error("comparator gain x2 not decoded");

	chk_cmp_gain_x1: assert property (
		regWrite && ctrlHit && regWrData[3:2] == GAIN_X1 |=> ##1
			cmpDacGain == 3'h1 && cmpDacBufOn)
		else $error("comparator gain x1 not decoded");

	chk_cmp_gain_off: assert property (
		regWrite && ctrlHit && regWrData[3:2] == GAIN_OFF |=> ##1
			cmpDacGain == 3'h0 && !cmpDacBufOn)
		else $error("comparator gain off not decoded");

	chk_adc_gain_x4: assert property (
		regWrite && ctrlHit && regWrData[1:0] == GAIN_X4 |=> ##1
			adcGain == 3'h4 && adcBufOn)
		else $error("converter gain x4 not decoded");

	chk_adc_gain_x2: assert property (
		regWrite && ctrlHit && regWrData[1:0] == GAIN_X2 |=> ##1
			adcGain == 3'h2 && adcBufOn)
		else $error("converter gain x2 not decoded");

	chk_adc_gain_x1: assert property (
		regWrite && ctrlHit && regWrData[1:0] == GAIN_X1 |=> ##1
			adcGain == 3'h1 && adcBufOn)
		else $error("converter gain x1 not decoded");

	chk_ready_on_expiry: assert property (
		refEnable && refAge == AW'(REF_CYC) |-> refReady)
		else $error("ready flag missing at settle expiry");

	chk_read_ctrl_data: assert property (
		regRead && ctrlHit |=> regRdData ==
			{$past(ctrl[7]), $past(refReady), $past(ctrl[5:0])})
		else $error("control read data wrong");

	chk_read_unmapped: assert property (
		regRead && !ctrlHit && !statusHit |=> regRdData == 8'h00)
		else $error("unmapped read not zero");

	chk_read_idle: assert property (
		!regRead |=> regRdData == 8'h00)
		else $error("read data stands past its cycle");

	cov_ref_ready: cover property (
		refEnable ##1 $rose(refReady));
	cov_gain_change: cover property (
		cmpDacBufOn && adcBufOn && cmpDacGain != adcGain);
	cov_temp_conv: cover property (
		tempConvAllowed && convStart);
	cov_read_ctrl: cover property (
		regRead && ctrlHit ##1 regRdData[READY_BIT]);

endmodule : rtsc_ctrl

// ===== rtsc_analog_model.sv
// far-side model: converter mux and start, keeping the waits
`timescale 1ns/1ps
module rtsc_analog_model #(
	parameter int unsigned WAIT = 14,
	parameter int unsigned BUF  = 12
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic muxReq,
	input  wire logic convReq,
	input  wire logic tempSensorOn,
	input  wire logic adcBufOn,
	output logic      convMuxTemp,
	output logic      convStart
);
	int unsigned age;
	int unsigned bufAge;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) convMuxTemp <= 1'b0;
		else convMuxTemp <= muxReq;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) age <= 0;
		else if (!convMuxTemp || !tempSensorOn || convStart) age <= 0;
		else if (age < WAIT) age <= age + 1;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) bufAge <= 0;
		else if (!adcBufOn) bufAge <= 0;
		else if (bufAge < BUF) bufAge <= bufAge + 1;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) convStart <= 1'b0;
		else convStart <= convReq && !convStart && age >= WAIT
			&& (!adcBufOn || bufAge >= BUF);
	end
endmodule : rtsc_analog_model

// ===== reference_temp_sense_control_tb.sv
// self-checking bench for the reference and temperature sense control
`timescale 1ns/1ps
module reference_temp_sense_control_tb;
	import rtsc_pkg::*;
	localparam int unsigned REF_N  = 8;
	localparam int unsigned BUF_N  = 10;
	localparam int unsigned TEMP_N = 12;
	typedef struct {
		logic [7:0] wr;
		logic [2:0] cmp;
		logic [2:0] adc;
	} rtsc_row_s;
	logic       ref_clk   = 1'b0;
	logic       rst       = 1'b0;
	logic [3:0] regAddr   = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWrite  = 1'b0;
	logic       regRead   = 1'b0;
	logic       muxReq    = 1'b0;
	logic       convReq   = 1'b0;
	logic [7:0] regRdData, rdStd, got, gotStd, w;
	logic [2:0] cmpDacGain, adcGain, c, g;
	logic       refEnable, refReady, tempSensorOn, tempRangeHigh;
	logic       tempToConverter, cmpDacBufOn, adcBufOn, readyStd;
	logic       convMuxTemp, convStart, tempConvAllowed;
	logic       lastStart = 1'b0;
	int         errTotal  = 0;
	int         nCompared = 0;
	int         nStarts   = 0;
	int         n;
	rtsc_row_s  rows [6] = '{'{8'h00, 3'h0, 3'h0}, '{8'hA5, 3'h1, 3'h1},
		'{8'h5A, 3'h2, 3'h2}, '{8'h1F, 3'h4, 3'h4},
		'{8'hFF, 3'h4, 3'h4}, '{8'h76, 3'h1, 3'h2}};

	always #2.5 ref_clk = ~ref_clk;

	rtsc_ctrl #(.REF_CYC(REF_N), .BUF_CYC(BUF_N), .TEMP_CYC(TEMP_N))
		i_rtsc_ctrl (
		.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .refEnable(refEnable), .refReady(refReady),
		.tempSensorOn(tempSensorOn), .tempRangeHigh(tempRangeHigh),
		.tempToConverter(tempToConverter), .cmpDacBufOn(cmpDacBufOn),
		.cmpDacGain(cmpDacGain), .adcBufOn(adcBufOn), .adcGain(adcGain),
		.convMuxTemp(convMuxTemp), .convStart(convStart),
		.tempConvAllowed(tempConvAllowed));

	// standard-supply variant beside the main one
	rtsc_ctrl #(.STD_SUPPLY(1'b1), .REF_CYC(REF_N), .BUF_CYC(BUF_N),
		.TEMP_CYC(TEMP_N)) i_rtsc_ctrl_std (
		.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(rdStd), .refEnable(), .refReady(readyStd),
		.tempSensorOn(), .tempRangeHigh(), .tempToConverter(),
		.cmpDacBufOn(), .cmpDacGain(), .adcBufOn(), .adcGain(),
		.convMuxTemp(convMuxTemp), .convStart(convStart),
		.tempConvAllowed());

	rtsc_analog_model #(.WAIT(TEMP_N + 2), .BUF(BUF_N)) i_rtsc_analog_model (
		.ref_clk(ref_clk), .rst(rst), .muxReq(muxReq), .convReq(convReq),
		.tempSensorOn(tempSensorOn), .adcBufOn(adcBufOn),
		.convMuxTemp(convMuxTemp), .convStart(convStart));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errTotal++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		cyc(1);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		got = regRdData;
		gotStd = rdStd;
		cyc(1);
	endtask : rd

	task automatic wrapUp;
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrapUp

	// start only when allowed, and allowance reloads after it
	always @(negedge ref_clk) begin
		if (convStart === 1'b1) begin
			nStarts++;
			chk({7'h0, tempConvAllowed}, 8'h01);
		end
		if (lastStart) chk({7'h0, tempConvAllowed}, 8'h00);
		lastStart = (convStart === 1'b1);
	end

	initial begin
		#10000;
		errTotal++;
		$display("ERROR %0t: watchdog expired", $time);
		wrapUp();
	end

	initial begin
		rst = 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(1);
		chk({refEnable, refReady, tempSensorOn, adcBufOn, 4'h0}, 8'h00);
		chk({7'h0, readyStd}, 8'h01);
		rd(CTRL_OFFSET);
		chk(got, CTRL_RESET);
		for (int i = 0; i < 6; i++) begin
			w = rows[i].wr;
			c = rows[i].cmp;
			g = rows[i].adc;
			wr(CTRL_OFFSET, w);
			chk({5'h0, refEnable, tempSensorOn, tempRangeHigh},
				{5'h0, w[7], w[5], w[4]});
			chk({2'h0, cmpDacGain, adcGain}, {2'h0, c, g});
			chk({6'h0, cmpDacBufOn, adcBufOn}, {6'h0, |c, |g});
			chk({7'h0, tempToConverter}, {7'h0, w[5]});
			rd(CTRL_OFFSET);
			chk(got, w & CTRL_WR_MASK);
			chk(gotStd, (w & CTRL_WR_MASK) | 8'h40);
		end
		// settle count from the enable edge
		wr(CTRL_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'h80);
		n = 1;
		while (refReady !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		chk(8'(n), 8'(REF_N));
		rd(CTRL_OFFSET);
		chk(got, 8'hC0);
		wr(CTRL_OFFSET, 8'h00);
		chk({7'h0, refReady}, 8'h00);
		chk({7'h0, readyStd}, 8'h01);
		// re-enable before expiry restarts the count
		wr(CTRL_OFFSET, 8'h80);
		cyc(4);
		wr(CTRL_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'h80);
		cyc(REF_N - 3);
		chk({7'h0, refReady}, 8'h00);
		cyc(3);
		chk({7'h0, refReady}, 8'h01);
		// reset in mid-run
		wr(CTRL_OFFSET, 8'hFF);
		rst <= 1'b1;
		cyc(1);
		chk({refEnable, refReady, tempSensorOn, cmpDacGain, 2'h0}, 8'h00);
		rst <= 1'b0;
		cyc(1);
		rd(CTRL_OFFSET);
		chk(got, 8'h00);
		// buffer settle status and refused accesses
		wr(CTRL_OFFSET, 8'h05);
		rd(STATUS_OFFSET);
		chk(got, 8'h00);
		cyc(BUF_N);
		rd(STATUS_OFFSET);
		chk(got, 8'h03);
		wr(STATUS_OFFSET, 8'hFF);
		wr(4'h7, 8'hFF);
		rd(CTRL_OFFSET);
		chk(got, 8'h05);
		rd(4'h9);
		chk(got, 8'h00);
		// sensor acquisition through the far side
		wr(CTRL_OFFSET, 8'h20);
		muxReq <= 1'b1;
		convReq <= 1'b1;
		cyc(TEMP_N / 2);
		chk({7'h0, tempConvAllowed}, 8'h00);
		cyc(60);
		convReq <= 1'b0;
		chk({7'h0, 1'(nStarts >= 3)}, 8'h01);
		muxReq <= 1'b0;
		cyc(3);
		chk({7'h0, tempConvAllowed}, 8'h00);
		wrapUp();
	end
endmodule : reference_temp_sense_control_tb
